// file: igd_pkg.sv
// Shared types and constants of the input gearbox deserializer
package igd_pkg;

   // Gearbox mode, static while a stream runs
   typedef enum logic [1:0] {
      igd_seven_bit_mode         = 2'b00,
      single_eight_bit_ddr_mode  = 2'b01,
      dual_four_bit_ddr_mode     = 2'b10
   } igd_mode_e;

   localparam int        IGD_WORD_W     = 8;
   localparam int        IGD_FIFO_DEPTH = 16;
   localparam logic [3:0] IGD_LEN_SEVEN = 4'h7;
   localparam logic [3:0] IGD_LEN_EIGHT = 4'h8;
   localparam logic [3:0] IGD_LEN_FOUR  = 4'h4;
   // Lane bit positions in dual four-bit mode
   localparam int        IGD_LANE_A_LSB = 4;
   localparam int        IGD_LANE_B_LSB = 0;
   localparam logic [7:0] IGD_WORD_RST  = 8'h00;
   // mclk cycles after reset before edge detection is trusted
   localparam logic [1:0] IGD_WARM_EDGES = 2'h3;

   // One bit per lane, captured on one edge-clock edge
   typedef struct packed {
      logic bit_a;
      logic bit_b;
   } igd_cap_s;

   // Parallel word with the mode it was assembled in
   typedef struct packed {
      logic [IGD_WORD_W-1:0] data;
      igd_mode_e             mode;
   } igd_word_s;

endpackage : igd_pkg

// file: igd_sync.sv
// Two-flop synchroniser for inputs from outside the mclk domain
`timescale 1ns/10ps
module igd_sync #(
   parameter int W = 1
) (
   input  wire logic         mclk,     // System clock
   input  wire logic         reset_n,  // Async reset, active low
   input  wire logic [W-1:0] async_in, // Unsynchronised levels
   output logic      [W-1:0] sync_out  // Levels in mclk domain
);
   logic [W-1:0] meta_q;
   logic [W-1:0] stab_q;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         meta_q <= '0;
         stab_q <= '0;
      end else begin
         meta_q <= async_in;
         stab_q <= meta_q;
      end
   end

   assign sync_out = stab_q;
endmodule : igd_sync

// file: igd_fifo.sv
// Word FIFO between the gearbox output stage and the core
`timescale 1ns/10ps
module igd_fifo #(
   parameter int W     = 10,
   parameter int DEPTH = 16
) (
   input  wire logic         mclk,      // System clock
   input  wire logic         reset_n,   // Async reset, active low
   input  wire logic         in_valid,  // Write request
   output logic              in_ready,  // Space available
   input  wire logic [W-1:0] in_data,   // Write word
   output logic              out_valid, // Word available
   input  wire logic         out_ready, // Read accept
   output logic      [W-1:0] out_data   // Head word
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];

   logic [W-1:0]  mem_q [DEPTH];
   logic [W-1:0]  mem_d [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0]   cnt_q, cnt_d;
   logic          push, pop;

   assign in_ready  = (cnt_q != FULL_CNT);
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_comb begin
      mem_d = mem_q;
      wr_d  = wr_q;
      rd_d  = rd_q;
      cnt_d = cnt_q;
      if (push) begin
         mem_d[wr_q] = in_data;
         wr_d        = wr_q + 1'b1;
      end
      if (pop) begin
         rd_d = rd_q + 1'b1;
      end
      case ({push, pop})
         2'b10:   cnt_d = cnt_q + 1'b1;
         2'b01:   cnt_d = cnt_q - 1'b1;
         default: cnt_d = cnt_q;
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         mem_q <= mem_d;
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   property p_full_blocks;
      @(posedge mclk) disable iff (!reset_n)
      (cnt_q == FULL_CNT) |-> !in_ready && (cnt_d == cnt_q - {{AW{1'b0}}, pop});
   endproperty
   a_full_blocks: assert property (p_full_blocks) else $error("FIFO accepted while full");

   property p_count_track;
      @(posedge mclk) disable iff (!reset_n)
      (push && !pop) |=> (cnt_q == $past(cnt_q) + 1'b1) && out_valid;
   endproperty
   a_count_track: assert property (p_count_track) else $error("FIFO count not advanced");
endmodule : igd_fifo

// file: igd_gearbox.sv
// Input gearbox: edge capture, word alignment, output stage and FIFO
`timescale 1ns/10ps
// Functional notes
// (R1) Modes: seven-bit, eight-bit, or dual four-bit
// (R2) Output bit placement follows the mode
// (R3) Three registered stages from input to word
// (R4) Stage one samples on both clock edges
// (R5) Stage two aligns under update and select
// (R6) Stage three registers word toward core
// (R7) Core alignment request slips word boundary
// (R8) Serial input taken after input delay
// (R9) Reset clears stages and alignment state
module igd_gearbox
   import igd_pkg::*;
(
   input  wire logic               mclk,               // System clock, 125 MHz
   input  wire logic               reset_n,            // Async reset, active low
   input  wire logic               fast_edge_clock,    // Edge clock from the link
   input  wire logic               serial_delayed_a,   // Lane A data after input delay
   input  wire logic               serial_delayed_b,   // Lane B data after input delay
   input  wire igd_pkg::igd_mode_e mode,               // Gearbox mode
   input  wire logic               word_align_request, // Slip boundary by one bit
   output igd_pkg::igd_word_s      word_out,           // Parallel word to core
   output logic                    word_valid,         // Word available
   input  wire logic               word_ready,         // Core takes the word
   output logic                    overrun             // Sticky: word lost
);
   import igd_pkg::*;

   localparam int WORD_BITS = $bits(igd_word_s);

   function automatic logic [3:0] word_len(input igd_mode_e m);
      case (m)
         igd_seven_bit_mode:        word_len = IGD_LEN_SEVEN;
         single_eight_bit_ddr_mode: word_len = IGD_LEN_EIGHT;
         dual_four_bit_ddr_mode:    word_len = IGD_LEN_FOUR;
         default:                   word_len = IGD_LEN_EIGHT;
      endcase
   endfunction : word_len

   // Synchronised link pins
   logic [2:0] sync_pins;
   logic       s_clk;
   igd_cap_s   s_bits;

   // (R8) Delayed data taken in
   igd_sync #(.W(3)) u_sync (
      .mclk     (mclk),
      .reset_n  (reset_n),
      .async_in ({fast_edge_clock, serial_delayed_a, serial_delayed_b}),
      .sync_out (sync_pins)
   );

   assign s_clk  = sync_pins[2];
   assign s_bits = igd_cap_s'(sync_pins[1:0]);

   // Stage one state
   logic       clk_prev_q, clk_prev_d;
   igd_cap_s   cap_q, cap_d;
   logic       cap_vld_q, cap_vld_d;
   logic       cap_en;
   // Sync warm-up, hides a false edge after reset
   logic [1:0] warm_q, warm_d;
   logic       warm_done;

   // Control and stage two state
   igd_mode_e  mode_q, mode_d;
   logic       slip_q, slip_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] sh_a_q, sh_a_d;
   logic [3:0] sh_b_q, sh_b_d;
   igd_word_s  align_q, align_d;
   logic       align_vld_q, align_vld_d;
   logic       align_select;
   logic       update_strobe;
   logic       take_bit;

   // Stage three state
   igd_word_s  out_q, out_d;
   logic       out_vld_q, out_vld_d;
   logic       overrun_q, overrun_d;
   logic       fifo_in_ready;
   logic       out_load;

   // (R4) Rising and falling edges
   assign warm_done = (warm_q == IGD_WARM_EDGES);
   assign cap_en    = (s_clk ^ clk_prev_q) & warm_done;

   always_comb begin
      clk_prev_d = s_clk;
      cap_vld_d  = cap_en;
      cap_d      = cap_en ? s_bits : cap_q;
      warm_d     = warm_done ? warm_q : warm_q + 2'h1;
   end

   // (R7) Slip consumes one bit
   assign align_select  = slip_q & cap_vld_q;
   assign take_bit      = cap_vld_q & ~align_select;
   // (R5) Word boundary update
   assign update_strobe = take_bit & (cnt_q == word_len(mode_q) - 4'h1);

   always_comb begin
      mode_d      = mode;
      slip_d      = slip_q;
      cnt_d       = cnt_q;
      sh_a_d      = sh_a_q;
      sh_b_d      = sh_b_q;
      align_d     = align_q;
      align_vld_d = update_strobe;
      // (R7) Request sets, set wins
      if (align_select) begin
         slip_d = 1'b0;
      end
      if (word_align_request) begin
         slip_d = 1'b1;
      end
      if (take_bit) begin
         sh_a_d = {sh_a_q[6:0], cap_q.bit_a};
         sh_b_d = {sh_b_q[2:0], cap_q.bit_b};
         cnt_d  = update_strobe ? 4'h0 : cnt_q + 4'h1;
      end
      // (R1) Mode change restarts the word
      if (mode != mode_q) begin
         cnt_d = 4'h0;
      end
      // (R2) Bit placement per mode
      if (update_strobe) begin
         align_d.mode = mode_q;
         case (mode_q)
            igd_seven_bit_mode: begin
               align_d.data = {1'b0, sh_a_q[5:0], cap_q.bit_a};
            end
            single_eight_bit_ddr_mode: begin
               align_d.data = {sh_a_q[6:0], cap_q.bit_a};
            end
            dual_four_bit_ddr_mode: begin
               align_d.data[IGD_LANE_A_LSB +: 4] = {sh_a_q[2:0], cap_q.bit_a};
               align_d.data[IGD_LANE_B_LSB +: 4] = {sh_b_q[2:0], cap_q.bit_b};
            end
            default: begin
               align_d.data = IGD_WORD_RST;
            end
         endcase
      end
   end

   // (R6) Output stage loads when free
   assign out_load = align_vld_q & (~out_vld_q | fifo_in_ready);

   always_comb begin
      out_d     = out_q;
      out_vld_d = out_vld_q;
      overrun_d = overrun_q;
      if (out_vld_q && fifo_in_ready) begin
         out_vld_d = 1'b0;
      end
      if (out_load) begin
         out_d     = align_q;
         out_vld_d = 1'b1;
      end
      if (align_vld_q && !out_load) begin
         overrun_d = 1'b1;
      end
   end

   // (R3) Three pipeline stages
   // (R9) Reset clears every stage
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         clk_prev_q  <= 1'b0;
         warm_q      <= 2'h0;
         cap_q       <= '0;
         cap_vld_q   <= 1'b0;
         mode_q      <= igd_seven_bit_mode;
         slip_q      <= 1'b0;
         cnt_q       <= 4'h0;
         sh_a_q      <= 8'h00;
         sh_b_q      <= 4'h0;
         align_q     <= '0;
         align_vld_q <= 1'b0;
         out_q       <= '0;
         out_vld_q   <= 1'b0;
         overrun_q   <= 1'b0;
      end else begin
         clk_prev_q  <= clk_prev_d;
         warm_q      <= warm_d;
         cap_q       <= cap_d;
         cap_vld_q   <= cap_vld_d;
         mode_q      <= mode_d;
         slip_q      <= slip_d;
         cnt_q       <= cnt_d;
         sh_a_q      <= sh_a_d;
         sh_b_q      <= sh_b_d;
         align_q     <= align_d;
         align_vld_q <= align_vld_d;
         out_q       <= out_d;
         out_vld_q   <= out_vld_d;
         overrun_q   <= overrun_d;
      end
   end

   logic [WORD_BITS-1:0] fifo_out;

   igd_fifo #(.W(WORD_BITS), .DEPTH(IGD_FIFO_DEPTH)) u_fifo (
      .mclk      (mclk),
      .reset_n   (reset_n),
      .in_valid  (out_vld_q),
      .in_ready  (fifo_in_ready),
      .in_data   (out_q),
      .out_valid (word_valid),
      .out_ready (word_ready),
      .out_data  (fifo_out)
   );

   assign word_out = igd_word_s'(fifo_out);
   assign overrun  = overrun_q;

   property p_cap_edge;
      @(posedge mclk) disable iff (!reset_n)
      cap_en |=> cap_vld_q && (cap_q == $past(s_bits));
   endproperty
   a_cap_edge: assert property (p_cap_edge) else $error("Edge sample missed"); // (R4)

   property p_both_edges;
      @(posedge mclk) disable iff (!reset_n)
      ($fell(s_clk) && warm_done) |-> cap_en;
   endproperty
   a_both_edges: assert property (p_both_edges) else $error("Falling edge ignored"); // (R4)

   property p_slip_set;
      @(posedge mclk) disable iff (!reset_n)
      word_align_request |=> slip_q;
   endproperty
   a_slip_set: assert property (p_slip_set) else $error("Align request lost"); // (R7)

   property p_slip_holds_count;
      @(posedge mclk) disable iff (!reset_n)
      (align_select && mode == mode_q) |=> (cnt_q == $past(cnt_q)) && !align_vld_q;
   endproperty
   a_slip_holds_count: assert property (p_slip_holds_count) else $error("Slip bit counted"); // (R5)

   property p_eight_len;
      @(posedge mclk) disable iff (!reset_n)
      (update_strobe && mode_q == single_eight_bit_ddr_mode) |-> (cnt_q == 4'h7);
   endproperty
   a_eight_len: assert property (p_eight_len) else $error("Eight-bit word length wrong"); // (R1)

   property p_seven_top;
      @(posedge mclk) disable iff (!reset_n)
      (align_vld_q && align_q.mode == igd_seven_bit_mode) |-> !align_q.data[7];
   endproperty
   a_seven_top: assert property (p_seven_top) else $error("Seven-bit word uses bit 7"); // (R2)

   property p_dual_lanes;
      @(posedge mclk) disable iff (!reset_n)
      (update_strobe && mode_q == dual_four_bit_ddr_mode)
         |=> align_q.data[4] == $past(cap_q.bit_a) && align_q.data[0] == $past(cap_q.bit_b);
   endproperty
   a_dual_lanes: assert property (p_dual_lanes) else $error("Lane bits misplaced"); // (R2)

   property p_stage_three;
      @(posedge mclk) disable iff (!reset_n)
      (align_vld_q && !out_vld_q) |=> out_vld_q && (out_q == $past(align_q));
   endproperty
   a_stage_three: assert property (p_stage_three) else $error("Output stage not loaded"); // (R6)

   property p_pipeline;
      @(posedge mclk) disable iff (!reset_n)
      update_strobe |=> align_vld_q ##1 out_vld_q;
   endproperty
   a_pipeline: assert property (p_pipeline) else $error("Pipeline stage skipped"); // (R3)

   property p_reset_clear;
      @(posedge mclk) disable iff (!reset_n)
      $rose(reset_n) |-> !word_valid && !out_vld_q && !slip_q && (word_out.data == IGD_WORD_RST);
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("State not cleared by reset"); // (R9)

   property p_mode_restart;
      @(posedge mclk) disable iff (!reset_n)
      (mode != mode_q) |=> (cnt_q == 4'h0);
   endproperty
   a_mode_restart: assert property (p_mode_restart) else $error("Mode change count"); // (R1)

   property p_short_len;
      @(posedge mclk) disable iff (!reset_n)
      (update_strobe && mode_q != single_eight_bit_ddr_mode)
         |-> (cnt_q == ((mode_q == igd_seven_bit_mode) ? 4'h6 : 4'h3));
   endproperty
   a_short_len: assert property (p_short_len) else $error("Short word length wrong"); // (R1)

   property p_slip_clear;
      @(posedge mclk) disable iff (!reset_n)
      (align_select && !word_align_request) |=> !slip_q;
   endproperty
   a_slip_clear: assert property (p_slip_clear) else $error("Slip applied twice"); // (R7)

   property p_drop_flag;
      @(posedge mclk) disable iff (!reset_n)
      (align_vld_q && out_vld_q && !fifo_in_ready) |=> overrun_q;
   endproperty
   a_drop_flag: assert property (p_drop_flag) else $error("Lost word not flagged"); // (R6)

   property p_drop_sticky;
      @(posedge mclk) disable iff (!reset_n)
      overrun_q |=> overrun_q;
   endproperty
   a_drop_sticky: assert property (p_drop_sticky) else $error("Overrun flag cleared"); // (R6)
endmodule : igd_gearbox

// file: igd_link_model.sv
// Serial source model: edge clock and two lanes of data
`timescale 1ns/10ps
module igd_link_model (
   output logic fast_edge_clock, // Edge clock, still between frames
   output logic serial_a,        // Lane A data
   output logic serial_b         // Lane B data
);
   initial begin
      fast_edge_clock = 1'b0;
      serial_a        = 1'b0;
      serial_b        = 1'b1;
   end

   // one bit per edge, first bit is the MSB
   task automatic send(input logic [7:0] a, input logic [7:0] b, input int n);
      #3;
      for (int i = n - 1; i >= 0; i--) begin
         serial_a = a[i];
         serial_b = b[i];
         #16;
         fast_edge_clock = ~fast_edge_clock;
         #16;
      end
      // Released lines show the inverse
      serial_a = ~serial_a;
      serial_b = ~serial_b;
   endtask : send
endmodule : igd_link_model

// file: igd_gearbox_tb.sv
// Testbench of the input gearbox deserializer
`timescale 1ns/10ps
module igd_gearbox_tb;
   import igd_pkg::*;
   logic        mclk               = 1'b0;
   logic        reset_n            = 1'b0;
   logic        fast_edge_clock;
   logic        ser_a;
   logic        ser_b;
   igd_mode_e   mode               = single_eight_bit_ddr_mode;
   logic        word_align_request = 1'b0;
   logic        word_ready         = 1'b0;
   igd_word_s   word_out;
   logic        word_valid;
   logic        overrun;
   logic        stall              = 1'b1;
   logic [31:0] lfsr_q             = 32'hd9e3834e;
   logic [31:0] rdy_lfsr_q         = 32'hd9e3834e;
   logic [7:0]  a;
   logic [7:0]  b;
   igd_word_s   exp_q[$];
   int          failures           = 0;
   int          total_checks       = 0;
   int          cycles             = 0;
   int          n;
   igd_mode_e   modes[3] = '{igd_seven_bit_mode, single_eight_bit_ddr_mode,
                             dual_four_bit_ddr_mode};

   always #4 mclk = ~mclk;

   igd_gearbox u_igd_gearbox (
      .mclk(mclk), .reset_n(reset_n), .fast_edge_clock(fast_edge_clock),
      .serial_delayed_a(ser_a), .serial_delayed_b(ser_b), .mode(mode),
      .word_align_request(word_align_request), .word_out(word_out),
      .word_valid(word_valid), .word_ready(word_ready), .overrun(overrun));

   igd_link_model u_igd_link_model (
      .fast_edge_clock(fast_edge_clock), .serial_a(ser_a), .serial_b(ser_b));

   function automatic logic [31:0] next_rand(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : next_rand

   function automatic int len_of(igd_mode_e m);
      if (m == igd_seven_bit_mode) return int'(IGD_LEN_SEVEN);
      if (m == dual_four_bit_ddr_mode) return int'(IGD_LEN_FOUR);
      return int'(IGD_LEN_EIGHT);
   endfunction : len_of

   function automatic igd_word_s expect_word(igd_mode_e m, logic [7:0] x, logic [7:0] y);
      igd_word_s w;
      w.mode = m;
      case (m)
         igd_seven_bit_mode:        w.data = {1'b0, x[6:0]};
         single_eight_bit_ddr_mode: w.data = x;
         default:                   w.data = {x[3:0], y[3:0]};
      endcase
      return w;
   endfunction : expect_word

   task automatic check_word(string what, igd_word_s exp, igd_word_s got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check_word

   task automatic check_bit(string what, logic exp, logic got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %b seen %b", what, exp, got);
      end
   endtask : check_bit

   task automatic give_verdict;
      $display("Checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : give_verdict

   task automatic tick(int k);
      repeat (k) @(posedge mclk);
   endtask : tick

   task automatic set_mode(igd_mode_e m);
      @(posedge mclk);
      mode <= m;
      tick(4);
   endtask : set_mode

   task automatic send_word(bit keep);
      tick(1);
      lfsr_q = next_rand(lfsr_q);
      a = lfsr_q[7:0];
      b = lfsr_q[15:8];
      if (keep) exp_q.push_back(expect_word(mode, a, b));
      u_igd_link_model.send(a, b, len_of(mode));
   endtask : send_word

   task automatic drain(string name);
      stall = 1'b0;
      n = 0;
      while (exp_q.size() != 0 && n < 3000) begin
         tick(1);
         n++;
      end
      check_bit("all words out", 1'b1, exp_q.size() == 0);
      $display("Test %s done", name);
   endtask : drain

   // Core side: random stalls, words checked in order
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         give_verdict();
      end
      if (word_valid === 1'b1 && word_ready === 1'b1) begin
         if (exp_q.size() == 0) check_bit("extra word", 1'b0, 1'b1);
         else check_word("word", exp_q.pop_front(), word_out);
      end
      rdy_lfsr_q = next_rand(rdy_lfsr_q);
      word_ready <= ~stall & rdy_lfsr_q[0];
   end

   initial begin
      tick(12);
      reset_n <= 1'b1;
      tick(4);
      stall = 1'b0;
      foreach (modes[i]) begin
         set_mode(modes[i]);
         repeat (6) send_word(1'b1);
      end
      drain("modes");
      stall = 1'b1;
      tick(2);
      send_word(1'b1);
      n = 0;
      while (word_valid !== 1'b1 && n < 20) begin
         tick(1);
         n++;
      end
      check_bit("latency", 1'b1, n >= 1 && n <= 6);
      drain("latency");
      foreach (modes[i]) begin
         set_mode(modes[i]);
         @(posedge mclk);
         word_align_request <= 1'b1;
         tick(2);
         word_align_request <= 1'b0;
         tick(2);
         // slipped bit ahead of a whole word
         u_igd_link_model.send(8'hff, 8'hff, 1);
         send_word(1'b1);
      end
      drain("align");
      set_mode(single_eight_bit_ddr_mode);
      u_igd_link_model.send(8'h05, 8'h05, 3);
      set_mode(igd_seven_bit_mode);
      send_word(1'b1);
      drain("mode change");
      set_mode(single_eight_bit_ddr_mode);
      stall = 1'b1;
      tick(2);
      check_bit("overrun idle", 1'b0, overrun);
      for (int k = 0; k < IGD_FIFO_DEPTH + 2; k++) send_word(k <= IGD_FIFO_DEPTH);
      tick(8);
      check_bit("overrun", 1'b1, overrun);
      drain("overrun");
      check_bit("overrun sticky", 1'b1, overrun);
      stall = 1'b1;
      tick(2);
      send_word(1'b0);
      tick(1);
      word_align_request <= 1'b1;
      tick(1);
      word_align_request <= 1'b0;
      reset_n <= 1'b0;
      tick(2);
      check_bit("valid in reset", 1'b0, word_valid);
      check_word("word in reset", '0, word_out);
      check_bit("overrun in reset", 1'b0, overrun);
      reset_n <= 1'b1;
      tick(4);
      send_word(1'b1);
      drain("reset");
      give_verdict();
   end
endmodule : igd_gearbox_tb
